// ===== core/fpp_pkg.sv
// constants shared by the flash protect and page program block
package fpp_pkg;

	// command opcodes
	localparam logic [7:0] OP_WRITE_REGS     = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG      = 8'h02;
	localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
	localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
	localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h32;

	// frame byte counts (opcode counted as byte one)
	localparam logic [2:0] CNT_CMD_ONLY   = 3'h1;
	localparam logic [2:0] CNT_WRR_STATUS = 3'h2;
	localparam logic [2:0] CNT_WRR_BOTH   = 3'h3;
	localparam logic [2:0] CNT_HEADER     = 3'h4;
	localparam logic [2:0] CNT_DATA_FIRST = 3'h5;
	localparam logic [2:0] CNT_SAT        = 3'h7;

	// register reset values and field positions
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam int         ST_STATUS_WRITE_DISABLE_BIT  = 7;
	localparam int         ST_BP_MSB    = 4;
	localparam int         ST_BP_LSB    = 2;
	localparam int         ST_WEL_BIT   = 1;
	localparam int         ST_WIP_BIT   = 0;
	localparam int         CFG_QUAD_BIT = 1;

	// array geometry and protection
	localparam int          PAGE_BYTES  = 256;
	localparam logic [7:0]  ERASED_BYTE = 8'hFF;
	localparam logic [7:0]  PAGE_LAST   = 8'hFF;
	localparam logic [24:0] ARRAY_SPAN  = 25'h1000000;
	localparam logic [2:0]  BP_NONE     = 3'h0;
	localparam logic [2:0]  BP_ALL      = 3'h7;

	// timing
	localparam int CLOCK_NS        = 100;
	localparam int PROG_SETTLE_NS  = 1600;
	localparam int REG_SETTLE_NS   = 800;
	localparam int PROG_SETTLE_CYC =
		(PROG_SETTLE_NS + CLOCK_NS - 1) / CLOCK_NS;
	localparam int REG_SETTLE_CYC  =
		(REG_SETTLE_NS + CLOCK_NS - 1) / CLOCK_NS;

	typedef enum logic [1:0] {
		ST_INIT,
		ST_IDLE,
		ST_PROG,
		ST_SETTLE
	} fpp_state_e;

endpackage

// ===== core/fpp_top.sv
// flash device logic: protection modes, register writes, page program
`timescale 1ns/1ps
`default_nettype none

module fpp_top
	import fpp_pkg::*;
#(
	parameter int MEM_AW = 12
) (
	// system clock and control
	input  wire logic              i_clock,
	input  wire logic              i_rstn,
	input  wire logic              i_clock_en,
	// serial link
	input  wire logic              i_sck,
	input  wire logic              i_cs_n,
	input  wire logic              i_io0,
	input  wire logic              i_io1,
	input  wire logic              i_io2,
	input  wire logic              i_io3,
	output logic                   o_io1_out,
	output logic                   o_io1_oe,
	// array read port
	input  wire logic [MEM_AW-1:0] i_rd_addr,
	output logic [7:0]             o_rd_data,
	// register and mode view
	output logic [7:0]             o_status,
	output logic [7:0]             o_config,
	output logic                   o_hw_protected
);

	initial begin
		if (MEM_AW < 9 || MEM_AW > 24)
			$error("MEM_AW must lie between 9 and 24");
	end

	fpp_state_e        state_reg;
	logic              lk_rst_reg, byte_done, wpar_reg, tog_reg;
	logic              partial_reg, quad_mode_reg, rd_par_reg;
	logic              byte_ev, fr_ok_reg, frame_start, frame_end;
	logic              cs_s1, cs_s2, cs_s3, cs_s4;
	logic              tog_s1, tog_s2, tog_s3, part_s1, part_s2;
	logic              wp_s1, wp_s2, status_write_disable_reg, wel_reg, wip_reg;
	logic              hpm_reg, hpm_now, prot_hit, exec_ok;
	logic              wrr_go, prog_go, prog_wr;
	logic [2:0]        bit_cnt_reg, bit_next, hdr_cnt_reg;
	logic [2:0]        fr_cnt_reg, bp_reg;
	logic [7:0]        shift_reg, shift_next, lk_op_reg;
	logic [7:0]        slot0_reg, slot1_reg, rx_byte, op_reg;
	logic [7:0]        ptr_reg, sr_new_reg, cr_new_reg, cfg_reg;
	logic [7:0]        walk_reg, settle_reg, prog_old_reg, rd_data_reg;
	logic [23:0]       addr_reg;
	logic [24:0]       prot_span;
	logic [7:0]        pbuf_mem [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] vld_reg;
	logic [7:0]        flash_mem [2**MEM_AW];
	logic [MEM_AW-1:0] init_reg, prog_idx;
	// link side: bit and header counting, restarted by chip select high
	// msb first, rising edge
	always_comb begin
		if (quad_mode_reg) begin
			shift_next = {shift_reg[3:0], i_io3, i_io2, i_io1, i_io0};
			bit_next   = bit_cnt_reg + 3'h4;
		end else begin
			shift_next = {shift_reg[6:0], i_io0};
			bit_next   = bit_cnt_reg + 3'h1;
		end
		byte_done = (bit_next == 3'h0);
	end

	always_ff @(posedge i_sck or posedge i_cs_n) begin
		if (i_cs_n) begin
			bit_cnt_reg   <= 3'h0;
			hdr_cnt_reg   <= 3'h0;
			quad_mode_reg <= 1'b0;
			shift_reg     <= 8'h00;
			lk_op_reg     <= 8'h00;
		end else begin
			shift_reg   <= shift_next;
			bit_cnt_reg <= bit_next;
			if (byte_done) begin
				if (hdr_cnt_reg == 3'h0)
					lk_op_reg <= shift_next;
				if (hdr_cnt_reg != CNT_HEADER)
					hdr_cnt_reg <= hdr_cnt_reg + 3'h1;
				if (hdr_cnt_reg == CNT_HEADER - 3'h1 &&
					lk_op_reg == OP_QUAD_PAGE_PROG)
					quad_mode_reg <= 1'b1;
			end
		end
	end

	// link side: byte hand-off slots with toggle event, boundary level
	always_ff @(posedge i_sck or posedge lk_rst_reg) begin
		if (lk_rst_reg) begin
			slot0_reg   <= 8'h00;
			slot1_reg   <= 8'h00;
			wpar_reg    <= 1'b0;
			tog_reg     <= 1'b0;
			partial_reg <= 1'b0;
		end else begin
			partial_reg <= (bit_next != 3'h0);
			if (byte_done) begin
				if (wpar_reg)
					slot1_reg <= shift_next;
				else
					slot0_reg <= shift_next;
				wpar_reg <= ~wpar_reg;
				tog_reg  <= ~tog_reg;
			end
		end
	end

	// link domain reset request, held through system reset
	always_ff @(posedge i_clock) begin
		if (!i_rstn)
			lk_rst_reg <= 1'b1;
		else if (i_clock_en)
			lk_rst_reg <= 1'b0;
	end

	// synchronisers into the system clock
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			{cs_s1, cs_s2, cs_s3, cs_s4} <= 4'hF;
			{tog_s1, tog_s2, tog_s3}     <= 3'h0;
			{part_s1, part_s2}           <= 2'h0;
			{wp_s1, wp_s2}               <= 2'h3;
		end else if (i_clock_en) begin
			{cs_s1, cs_s2, cs_s3, cs_s4} <= {i_cs_n, cs_s1, cs_s2, cs_s3};
			{tog_s1, tog_s2, tog_s3}     <= {tog_reg, tog_s1, tog_s2};
			{part_s1, part_s2}           <= {partial_reg, part_s1};
			{wp_s1, wp_s2}               <= {i_io2, wp_s1};
		end
	end

	// end of frame seen one stage after the last byte event
	assign byte_ev     = tog_s2 ^ tog_s3;
	assign rx_byte     = rd_par_reg ? slot1_reg : slot0_reg;
	assign frame_start = !cs_s2 && cs_s3;
	assign frame_end   = cs_s3 && !cs_s4;

	// protection mode and block protect decode
	always_comb begin
		// quad enable takes the pin away
		hpm_now = !wp_s2 && status_write_disable_reg && !cfg_reg[CFG_QUAD_BIT];
		if (bp_reg == BP_NONE)
			prot_span = 25'h0000000;
		else if (bp_reg == BP_ALL)
			prot_span = ARRAY_SPAN;
		else
			prot_span = ARRAY_SPAN >> (BP_ALL - bp_reg);
		// same check whatever the protection mode
		prot_hit = (bp_reg != BP_NONE) &&
			({1'b0, addr_reg} >= ARRAY_SPAN - prot_span);
	end

	// command decode at the end of an accepted frame
	always_comb begin
		// off a byte boundary nothing executes
		exec_ok = frame_end && fr_ok_reg && !part_s2 &&
			state_reg == ST_IDLE;
		// write registers ignored under hardware protection
		wrr_go  = exec_ok && op_reg == OP_WRITE_REGS && wel_reg &&
			!hpm_now && (fr_cnt_reg == CNT_WRR_STATUS ||
			fr_cnt_reg == CNT_WRR_BOTH);
		prog_go = exec_ok && wel_reg && !prot_hit &&
			fr_cnt_reg >= CNT_DATA_FIRST &&
			(op_reg == OP_PAGE_PROG ||
			(op_reg == OP_QUAD_PAGE_PROG && cfg_reg[CFG_QUAD_BIT]));
	end

	// frame capture: opcode, address, register data, page buffer
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			rd_par_reg <= 1'b0;
			fr_ok_reg  <= 1'b0;
			fr_cnt_reg <= 3'h0;
			op_reg     <= 8'h00;
			addr_reg   <= 24'h000000;
			ptr_reg    <= 8'h00;
			sr_new_reg <= 8'h00;
			cr_new_reg <= 8'h00;
			vld_reg    <= '0;
		end else if (i_clock_en) begin
			if (byte_ev)
				rd_par_reg <= ~rd_par_reg;
			if (frame_start) begin
				fr_ok_reg  <= (state_reg == ST_IDLE);
				fr_cnt_reg <= 3'h0;
				vld_reg    <= '0;
			end else if (byte_ev) begin
				if (fr_cnt_reg != CNT_SAT)
					fr_cnt_reg <= fr_cnt_reg + 3'h1;
				if (fr_cnt_reg == 3'h0)
					op_reg <= rx_byte;
				if (fr_cnt_reg == 3'h1)
					sr_new_reg <= rx_byte;
				if (fr_cnt_reg == 3'h2)
					cr_new_reg <= rx_byte;
				// three address bytes after the opcode
				if (fr_cnt_reg != 3'h0 && fr_cnt_reg < CNT_HEADER)
					addr_reg <= {addr_reg[15:0], rx_byte};
				if (fr_cnt_reg == CNT_HEADER - 3'h1)
					ptr_reg <= rx_byte;
				if (fr_cnt_reg >= CNT_HEADER) begin
					ptr_reg          <= ptr_reg + 8'h01;
					vld_reg[ptr_reg] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_clock_en && byte_ev && fr_cnt_reg >= CNT_HEADER)
			pbuf_mem[ptr_reg] <= rx_byte;
	end

	// sequencer: power-up erase fill, program walk, settle time
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			state_reg  <= ST_INIT;
			init_reg   <= '0;
			walk_reg   <= 8'h00;
			settle_reg <= 8'h00;
		end else if (i_clock_en) begin
			unique case (state_reg)
			ST_INIT: begin
				init_reg <= init_reg + 1'b1;
				if (&init_reg)
					state_reg <= ST_IDLE;
			end
			ST_IDLE: begin
				// cycle starts once chip select rises
				if (prog_go) begin
					walk_reg  <= 8'h00;
					state_reg <= ST_PROG;
				end else if (wrr_go) begin
					settle_reg <= 8'(REG_SETTLE_CYC - 1);
					state_reg  <= ST_SETTLE;
				end
			end
			ST_PROG: begin
				walk_reg <= walk_reg + 8'h01;
				if (walk_reg == PAGE_LAST) begin
					settle_reg <= 8'(PROG_SETTLE_CYC - 1);
					state_reg  <= ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				settle_reg <= settle_reg - 8'h01;
				if (settle_reg == 8'h00)
					state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// array: erase fill after reset, program clears bits only
	assign prog_idx = {addr_reg[MEM_AW-1:8], walk_reg};
	// only bytes that arrived are touched
	assign prog_wr  = state_reg == ST_PROG && vld_reg[walk_reg];

	always_ff @(posedge i_clock) begin
		if (i_clock_en) begin
			if (state_reg == ST_INIT)
				flash_mem[init_reg] <= ERASED_BYTE;
			// new value is old AND loaded data
			else if (prog_wr)
				flash_mem[prog_idx] <= flash_mem[prog_idx] &
					pbuf_mem[walk_reg];
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			rd_data_reg  <= 8'h00;
			prog_old_reg <= 8'h00;
		end else if (i_clock_en) begin
			rd_data_reg  <= flash_mem[i_rd_addr];
			prog_old_reg <= flash_mem[prog_idx];
		end
	end

	// status and configuration registers
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			status_write_disable_reg <= STATUS_RESET[ST_STATUS_WRITE_DISABLE_BIT];
			bp_reg   <= STATUS_RESET[ST_BP_MSB:ST_BP_LSB];
			cfg_reg  <= CONFIG_RESET;
		end else if (i_clock_en && wrr_go) begin
			status_write_disable_reg <= sr_new_reg[ST_STATUS_WRITE_DISABLE_BIT];
			bp_reg   <= sr_new_reg[ST_BP_MSB:ST_BP_LSB];
			if (fr_cnt_reg == CNT_WRR_BOTH)
				cfg_reg <= cr_new_reg;
		end
	end

	// write enable latch and busy flag
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			wel_reg <= STATUS_RESET[ST_WEL_BIT];
			wip_reg <= 1'b1;
		end else if (i_clock_en) begin
			if (exec_ok && op_reg == OP_WRITE_ENABLE &&
				fr_cnt_reg == CNT_CMD_ONLY)
				wel_reg <= 1'b1;
			else if (exec_ok && op_reg == OP_WRITE_DISABLE &&
				fr_cnt_reg == CNT_CMD_ONLY)
				wel_reg <= 1'b0;
			// cleared on the last settle cycle
			else if (state_reg == ST_SETTLE && settle_reg == 8'h00)
				wel_reg <= 1'b0;
			// busy while program or register cycle runs
			wip_reg <= !(state_reg == ST_IDLE && !prog_go && !wrr_go) &&
				!(state_reg == ST_SETTLE && settle_reg == 8'h00) &&
				!(state_reg == ST_INIT && &init_reg);
		end
	end

	// hardware protection mode flag and pin outputs
	always_ff @(posedge i_clock) begin
		if (!i_rstn) begin
			hpm_reg   <= 1'b0;
			o_io1_out <= 1'b0;
			o_io1_oe  <= 1'b0;
		end else if (i_clock_en) begin
			// leaves only when the pin rises
			hpm_reg   <= hpm_now;
			o_io1_out <= 1'b0;
			o_io1_oe  <= 1'b0;
		end
	end

	assign o_status = {status_write_disable_reg, 2'b00, bp_reg, wel_reg, wip_reg};
	assign o_config       = cfg_reg;
	assign o_hw_protected = hpm_reg;
	assign o_rd_data      = rd_data_reg;

	// checks on the system clock
	a_hpm_both_needed: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$past(i_clock_en) && o_hw_protected |->
			$past(!wp_s2 && status_write_disable_reg && !cfg_reg[CFG_QUAD_BIT]))
		else $error("protection mode without both conditions");
	a_hpm_regs_frozen: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		hpm_now |=> $stable({status_write_disable_reg, bp_reg, cfg_reg}))
		else $error("registers changed under hardware protection");
	a_prog_needs_wel: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$rose(state_reg == ST_PROG) |-> $past(wel_reg))
		else $error("program started without write enable");
	a_prog_clears_only: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		prog_wr && i_clock_en |=>
			(flash_mem[$past(prog_idx)] & ~prog_old_reg) == 8'h00)
		else $error("program set a bit to one");
	a_wip_in_cycle: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$rose(state_reg == ST_PROG) |->
			wip_reg [*8] ##[1:400] !wip_reg)
		else $error("busy flag wrong around program cycle");
	a_wel_cleared_end: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$fell(wip_reg) |-> !wel_reg)
		else $error("latch still set after cycle end");
	a_quad_needs_qe: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$rose(state_reg == ST_PROG) && op_reg == OP_QUAD_PAGE_PROG
			|-> $past(cfg_reg[CFG_QUAD_BIT]))
		else $error("quad program without quad enable");
	a_protected_refused: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		$rose(state_reg == ST_PROG) |-> !$past(prot_hit))
		else $error("program of a protected page");
	a_partial_discard: assert property (
		@(posedge i_clock) disable iff (!i_rstn)
		frame_end && part_s2 |=> state_reg != ST_PROG)
		else $error("broken frame was executed");

endmodule

`default_nettype wire

// ===== sim/fpp_host.sv
// host controller model driving the serial flash link
`timescale 1ns/1ps
`default_nettype none
module fpp_host (
	// serial link
	output logic o_sck,
	output logic o_cs_n,
	output logic o_io0,
	output logic o_io1,
	output logic o_io2,
	output logic o_io3
);
	logic [7:0] buf_q [0:299];
	logic       wp;

	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		{o_io3, o_io1, o_io0} = 3'h0;
		wp = 1'b1;
		o_io2 = 1'b1;
	end

	// protect pin level while not in a quad data phase
	task set_wp(input logic v);
		wp = v;
		o_io2 = v;
	endtask

	// one link clock of 125 ns, data set while the clock is low
	task bitx(input logic [3:0] v, input int q);
		if (q != 0)
			{o_io3, o_io2, o_io1, o_io0} = v;
		else
			o_io0 = v[0];
		#62.5 o_sck = 1'b1;
		#62.5 o_sck = 1'b0;
	endtask

	task send(input int n, input int q, input int extra);
		int i;
		int b;
		o_cs_n = 1'b0;
		#100;
		for (i = 0; i < n; i++) begin
			// quad data phase, high nibble first
			if (q != 0 && i >= 4) begin
				bitx(buf_q[i][7:4], 1);
				bitx(buf_q[i][3:0], 1);
			end else begin
				for (b = 7; b >= 0; b--)
					bitx({3'h0, buf_q[i][b]}, 0);
			end
		end
		// optional stray bits off the byte boundary
		for (b = 0; b < extra; b++)
			bitx(4'h1, 0);
		#100;
		o_cs_n = 1'b1;
		o_io0 = ~o_io0;
		o_io1 = ~o_io1;
		o_io3 = ~o_io3;
		o_io2 = wp;
		#600;
	endtask
endmodule
`default_nettype wire

// ===== sim/test_flash_protect_page_program.sv
// self-checking bench for the protect and page program block
`timescale 1ns/1ps
`default_nettype none
module test_flash_protect_page_program;
	import fpp_pkg::*;
	logic       i_clock = 1'b0;
	logic       i_rstn = 1'b0;
	logic [8:0] rd_addr = 9'h000;
	wire        sck, cs_n, io0, io1h, io2, io3;
	logic       io1_out, io1_oe, hwp;
	logic [7:0] rd_data, status, cfg;
	int         error_cnt = 0;
	int         samples_checked = 0;
	int         i;

	always #50 i_clock = ~i_clock;

	fpp_host host_u (.o_sck(sck), .o_cs_n(cs_n), .o_io0(io0),
		.o_io1(io1h), .o_io2(io2), .o_io3(io3));

	fpp_top #(.MEM_AW(9)) dut_u (.i_clock(i_clock), .i_rstn(i_rstn),
		.i_clock_en(1'b1), .i_sck(sck), .i_cs_n(cs_n), .i_io0(io0),
		.i_io1(io1_oe ? io1_out : io1h), .i_io2(io2), .i_io3(io3),
		.o_io1_out(io1_out), .o_io1_oe(io1_oe), .i_rd_addr(rd_addr),
		.o_rd_data(rd_data), .o_status(status), .o_config(cfg),
		.o_hw_protected(hwp));

	task chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task chk1(input string nm, input logic e, input logic g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask

	task results;
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge i_clock) rd_addr <= a;
		repeat (2) @(posedge i_clock);
		#1 chk8($sformatf("array_%h", a), e, rd_data);
	endtask

	task cmd(input logic [7:0] op);
		host_u.buf_q[0] = op;
		host_u.send(1, 0, 0);
	endtask

	task prog(input logic [7:0] op, input logic [23:0] a, input int n,
		input int x);
		host_u.buf_q[0] = op;
		{host_u.buf_q[1], host_u.buf_q[2], host_u.buf_q[3]} = a;
		host_u.send(4 + n, int'(op == OP_QUAD_PAGE_PROG), x);
	endtask

	task write_registers_cmd(input logic [7:0] s, input logic [7:0] c, input int n);
		host_u.buf_q[0] = OP_WRITE_REGS;
		host_u.buf_q[1] = s;
		host_u.buf_q[2] = c;
		host_u.send(1 + n, 0, 0);
	endtask

	task busy;
		int k;
		k = 0;
		// busy after chip select rise, idle when done
		chk1("wip_busy", 1'b1, status[0]);
		while (status[0] !== 1'b0 && k < 400) begin
			@(posedge i_clock);
			k++;
		end
		chk1("wip_idle", 1'b0, status[0]);
	endtask

	task pin(input logic v);
		host_u.set_wp(v);
		repeat (6) @(posedge i_clock);
	endtask

	initial begin
		repeat (16) @(posedge i_clock);
		i_rstn <= 1'b1;
		for (i = 0; i < 700 && status[0] !== 1'b0; i++)
			@(posedge i_clock);
		chk8("status", STATUS_RESET, status);
		chk8("config", CONFIG_RESET, cfg);
		host_u.buf_q[4] = 8'h00;
		prog(OP_PAGE_PROG, 24'h000005, 1, 0);
		rd(9'h005, 8'hFF);
		cmd(OP_WRITE_ENABLE);
		chk8("status", 8'h02, status);
		cmd(OP_WRITE_DISABLE);
		chk8("status", 8'h00, status);
		cmd(OP_WRITE_ENABLE);
		prog(OP_QUAD_PAGE_PROG, 24'h000030, 1, 0);
		rd(9'h030, 8'hFF);
		{host_u.buf_q[4], host_u.buf_q[5], host_u.buf_q[6]} = 24'hA53C0F;
		prog(OP_PAGE_PROG, 24'h0000FE, 3, 0);
		busy();
		chk8("status", 8'h00, status);
		rd(9'h0FE, 8'hA5);
		rd(9'h0FF, 8'h3C);
		rd(9'h000, 8'h0F);
		rd(9'h001, 8'hFF);
		cmd(OP_WRITE_ENABLE);
		host_u.buf_q[4] = 8'hF0;
		prog(OP_PAGE_PROG, 24'h0000FE, 1, 0);
		busy();
		rd(9'h0FE, 8'hA0);
		cmd(OP_WRITE_ENABLE);
		for (i = 0; i < 258; i++)
			host_u.buf_q[4 + i] = (i < 2) ? 8'h00 : 8'hC3;
		prog(OP_PAGE_PROG, 24'h000100, 258, 0);
		busy();
		rd(9'h100, 8'hC3);
		rd(9'h101, 8'hC3);
		cmd(OP_WRITE_ENABLE);
		host_u.buf_q[4] = 8'h00;
		prog(OP_PAGE_PROG, 24'h000040, 1, 3);
		repeat (10) @(posedge i_clock);
		rd(9'h040, 8'hFF);
		cmd(OP_WRITE_DISABLE);
		write_registers_cmd(8'h04, 8'h00, 1);
		repeat (10) @(posedge i_clock);
		chk8("status", 8'h00, status);
		cmd(OP_WRITE_ENABLE);
		write_registers_cmd(8'h9C, 8'h00, 2);
		busy();
		chk8("status", 8'h9C, status);
		chk1("hw_protected", 1'b0, hwp);
		pin(1'b0);
		chk1("hw_protected", 1'b1, hwp);
		cmd(OP_WRITE_ENABLE);
		write_registers_cmd(8'h00, 8'h00, 2);
		repeat (10) @(posedge i_clock);
		chk8("status", 8'h9E, status);
		host_u.buf_q[4] = 8'h00;
		prog(OP_PAGE_PROG, 24'h000050, 1, 0);
		repeat (10) @(posedge i_clock);
		rd(9'h050, 8'hFF);
		cmd(OP_WRITE_DISABLE);
		pin(1'b1);
		chk1("hw_protected", 1'b0, hwp);
		cmd(OP_WRITE_ENABLE);
		write_registers_cmd(8'h10, 8'h00, 1);
		busy();
		chk8("status", 8'h10, status);
		pin(1'b0);
		chk1("hw_protected", 1'b0, hwp);
		cmd(OP_WRITE_ENABLE);
		prog(OP_PAGE_PROG, 24'hE00010, 1, 0);
		repeat (10) @(posedge i_clock);
		rd(9'h010, 8'hFF);
		host_u.buf_q[4] = 8'h55;
		prog(OP_PAGE_PROG, 24'h000010, 1, 0);
		busy();
		rd(9'h010, 8'h55);
		cmd(OP_WRITE_ENABLE);
		write_registers_cmd(8'h90, 8'h00, 2);
		busy();
		chk1("hw_protected", 1'b1, hwp);
		pin(1'b1);
		cmd(OP_WRITE_ENABLE);
		write_registers_cmd(8'h80, 8'h02, 2);
		busy();
		chk8("config", 8'h02, cfg);
		pin(1'b0);
		chk1("hw_protected", 1'b0, hwp);
		cmd(OP_WRITE_ENABLE);
		{host_u.buf_q[4], host_u.buf_q[5]} = 16'h1234;
		prog(OP_QUAD_PAGE_PROG, 24'h000080, 2, 0);
		busy();
		rd(9'h080, 8'h12);
		rd(9'h081, 8'h34);
		chk1("io1_oe", 1'b0, io1_oe);
		chk1("io1_out", 1'b0, io1_out);
		results();
	end

	initial begin
		repeat (40000) @(posedge i_clock);
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
